// [shared/ssc_pkg.sv]
package ssc_pkg;

  localparam logic [7:0] ADDR_STANDBY = 8'h00;
  localparam logic [7:0] ADDR_SETTLE_SEL = 8'h01;
  localparam logic [7:0] ADDR_PCFG = 8'h02;
  localparam logic [7:0] ADDR_STAT = 8'h03;

  localparam int STANDBY_STOP_BIT = 1;
  localparam logic [7:0] STANDBY_WR_MASK = 8'h02;
  localparam logic [7:0] STANDBY_RST = 8'h00;
  localparam logic [2:0] SETTLE_SEL_RST = 3'h4;
  localparam logic [7:0] PCFG_RST = 8'h00;

  localparam int PCFG_T12_EXT = 0;
  localparam int PCFG_T56_EXT = 1;
  localparam int PCFG_T78_EXT = 2;
  localparam int PCFG_WT_SUB = 3;
  localparam int PCFG_SIO_EXT = 4;
  localparam int PCFG_I2C_MODE = 5;
  localparam int PCFG_RTO_TRIG = 6;
  localparam int PCFG_SUB_PRES = 7;

  localparam logic [7:0] ADDR_LOW_STOP = 8'hC0;

  localparam int CLK_PERIOD_NS = 50;
  localparam int SETTLE_CNT_W = 24;
  localparam int SETTLE_BASE_DFLT = 10;

  typedef enum logic [1:0] {
    SSC_RUN,
    SSC_STOP,
    SSC_SETTLE
  } ssc_mode_e;

  typedef struct packed {
    logic [6:0] ext_req;
    logic [6:0] ext_mk;
    logic       wt_req;
    logic       wt_mk;
    logic [7:0] key_req;
    logic [7:0] key_mk;
    logic       nmi_edge;
  } ssc_wake_s;

  typedef struct packed {
    logic       tmr16;
    logic [2:0] tmr8;
    logic       wt;
    logic       wdt;
    logic       adc;
    logic       dac;
    logic       rto;
    logic       sio;
    logic       i2c;
  } ssc_gate_s;

  typedef struct packed {
    logic       ad_oe;
    logic       ah_oe;
    logic       addr_strobe_oe;
    logic       rdwr_oe;
    logic       wait_oe;
    logic [7:0] al;
  } ssc_bus_s;

  typedef struct packed {
    logic                    busy;
    logic                    done;
    logic [SETTLE_CNT_W-1:0] cnt;
  } ssc_settle_s;

  typedef struct packed {
    ssc_mode_e  mode;
    logic [7:0] standby_reg;
    logic [2:0] settle_sel;
    logic [7:0] pcfg;
    logic [7:0] rdata;
    ssc_gate_s  gate;
    ssc_bus_s   bus;
    logic       osc_en;
    logic       sub_en;
    logic       cpu_run;
    logic       latch_hold;
    logic       irq_hold;
    logic       boot_vec;
    logic       settle_go;
  } ssc_top_s;

endpackage

// [src/ssc_wake_detect.sv]
`timescale 1ns/1ps
module ssc_wake_detect
  import ssc_pkg::*;
(
  input  wire ssc_wake_s src_i,
  input  wire logic      wt_sub_i,
  input  wire logic      sub_pres_i,
  output logic           wake_o
);

  logic ext_hit;
  logic key_hit;
  logic wt_hit;

  always_comb begin
    ext_hit = |(src_i.ext_req & ~src_i.ext_mk);
    key_hit = |(src_i.key_req & ~src_i.key_mk);
    // watch timer only ticks in standby from the subsystem clock
    wt_hit = src_i.wt_req & ~src_i.wt_mk & wt_sub_i & sub_pres_i;
    // flags already pending on entry count as a wake as well
    wake_o = ext_hit | key_hit | wt_hit | src_i.nmi_edge;
  end

endmodule

// [src/ssc_settle_timer.sv]
`timescale 1ns/1ps
module ssc_settle_timer
  import ssc_pkg::*;
#(
  parameter int SETTLE_BASE = SETTLE_BASE_DFLT
)(
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       start_i,
  input  wire logic [2:0] sel_i,
  output logic            done_o
);

  ssc_settle_s q;
  ssc_settle_s d;

  always_comb begin
    d = q;
    d.done = 1'b0;
    if (start_i) begin
      d.busy = 1'b1;
      d.cnt = SETTLE_CNT_W'((64'd1 << (SETTLE_BASE + int'(sel_i))) - 64'd1);
    end else if (q.busy) begin
      if (q.cnt == '0) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end else begin
        d.cnt = q.cnt - SETTLE_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done_o = q.done;

endmodule

// [src/ssc_stop_ctrl.sv]
// Operation
// - a reset that ends standby restarts the cpu at the reset vector and never clears ram.
// - writing the stop request bit to 1 puts the block into stop mode.
// - the standby control register takes only byte writes made by the special move.
// - a source already pending and unmasked at entry releases standby at once.
// - release waits the settling time chosen in the settle select register.
// - in stop only the main oscillator halts; the subsystem clock keeps running.
// - in stop the cpu halts and every port output latch holds its value.
// - in stop the 16-bit timer stops and each 8-bit pair runs only on its external clock.
// - in stop the watch timer runs only with a subsystem clock selected as its clock.
// - in stop real-time output runs only on external trigger or timers 1 and 2 external.
// - in stop serial runs only on an external clock, and i2c mode stops.
// - in stop the bus lines float and the low address lines drive C0H.
// - in stop only external, watch timer and key return interrupts and a valid nmi edge release the mode.
// - a valid nmi edge in stop restarts the oscillator and ends stop after settling.
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module ssc_stop_ctrl
  import ssc_pkg::*;
#(
  parameter int SETTLE_BASE = SETTLE_BASE_DFLT
)(
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       we_i,
  input  wire logic       re_i,
  input  wire logic       spec_mov_i,
  output logic      [7:0] rdata_o,
  input  wire ssc_wake_s  wake_src_i,
  input  wire logic [7:0] cpu_addr_low_i,
  input  wire logic       cpu_ad_oe_i,
  input  wire logic       cpu_ah_oe_i,
  input  wire logic       cpu_addr_strobe_oe_i,
  input  wire logic       cpu_rdwr_oe_i,
  input  wire logic       cpu_wait_oe_i,
  output ssc_bus_s        bus_o,
  output ssc_gate_s       gate_o,
  output logic            main_osc_en_o,
  output logic            sub_osc_en_o,
  output logic            cpu_run_o,
  output logic            latch_hold_o,
  output logic            irq_hold_o,
  output logic            boot_vec_o
);

  ssc_top_s q;
  ssc_top_s d;
  logic     wake;
  logic     settle_done;
  logic     standby;
  logic     stop_req;

  ssc_wake_detect u_wake (
    .src_i      (wake_src_i),
    .wt_sub_i   (q.pcfg[PCFG_WT_SUB]),
    .sub_pres_i (q.pcfg[PCFG_SUB_PRES]),
    .wake_o     (wake)
  );

  ssc_settle_timer #(
    .SETTLE_BASE (SETTLE_BASE)
  ) u_settle (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .start_i (q.settle_go),
    .sel_i   (q.settle_sel),
    .done_o  (settle_done)
  );

  always_comb begin
    d = q;
    d.boot_vec = 1'b0;
    d.settle_go = 1'b0;
    d.rdata = 8'h00;
    stop_req = 1'b0;

    // register writes; the cpu is halted in standby so none arrive there
    if (we_i) begin
      if (addr_i == ADDR_STANDBY) begin
        // ordinary stores are dropped so a stray write cannot stop the clock
        if (spec_mov_i) begin
          d.standby_reg = wdata_i & STANDBY_WR_MASK;
          stop_req = wdata_i[STANDBY_STOP_BIT];
        end
      end else if (addr_i == ADDR_SETTLE_SEL) begin
        d.settle_sel = wdata_i[2:0];
      end else if (addr_i == ADDR_PCFG) begin
        d.pcfg = wdata_i;
      end
    end

    // register reads, answer one cycle later
    if (re_i) begin
      if (addr_i == ADDR_STANDBY) begin
        d.rdata = q.standby_reg;
      end else if (addr_i == ADDR_SETTLE_SEL) begin
        d.rdata = {5'h00, q.settle_sel};
      end else if (addr_i == ADDR_PCFG) begin
        d.rdata = q.pcfg;
      end else if (addr_i == ADDR_STAT) begin
        d.rdata = {5'h00, wake, q.mode};
      end else begin
        d.rdata = 8'h00;
      end
    end

    case (q.mode)
      SSC_RUN: begin
        if (stop_req) begin
          d.mode = SSC_STOP;
          // a pending unmasked source skips the sleep
          if (wake) begin
            d.mode = SSC_SETTLE;
            d.settle_go = 1'b1;
          end
        end
      end
      SSC_STOP: begin
        // other requests stay pending, only these sources wake
        if (wake) begin
          d.mode = SSC_SETTLE;
          d.settle_go = 1'b1;
        end
      end
      SSC_SETTLE: begin
        if (settle_done) begin
          d.mode = SSC_RUN;
          d.standby_reg[STANDBY_STOP_BIT] = 1'b0;
        end
      end
      default: begin
        d.mode = SSC_RUN;
      end
    endcase

    standby = (d.mode != SSC_RUN);

    // oscillator restarts at the start of settling, not at its end
    d.osc_en = (d.mode != SSC_STOP);
    d.sub_en = q.pcfg[PCFG_SUB_PRES];
    d.cpu_run = ~standby;
    d.latch_hold = standby;
    d.irq_hold = standby;

    d.gate.tmr16 = ~standby;
    d.gate.tmr8[0] = ~standby | q.pcfg[PCFG_T12_EXT];
    d.gate.tmr8[1] = ~standby | q.pcfg[PCFG_T56_EXT];
    d.gate.tmr8[2] = ~standby | q.pcfg[PCFG_T78_EXT];
    d.gate.wt = ~standby | (q.pcfg[PCFG_WT_SUB] & q.pcfg[PCFG_SUB_PRES]);
    d.gate.wdt = ~standby;
    d.gate.adc = ~standby;
    d.gate.dac = 1'b1;
    d.gate.rto = ~standby | q.pcfg[PCFG_RTO_TRIG] | q.pcfg[PCFG_T12_EXT];
    d.gate.sio = ~standby | (q.pcfg[PCFG_SIO_EXT] & ~q.pcfg[PCFG_I2C_MODE]);
    d.gate.i2c = ~standby & q.pcfg[PCFG_I2C_MODE];

    if (standby) begin
      d.bus.ad_oe = 1'b0;
      d.bus.ah_oe = 1'b0;
      d.bus.addr_strobe_oe = 1'b0;
      d.bus.rdwr_oe = 1'b0;
      d.bus.wait_oe = 1'b0;
      d.bus.al = ADDR_LOW_STOP;
    end else begin
      d.bus.ad_oe = cpu_ad_oe_i;
      d.bus.ah_oe = cpu_ah_oe_i;
      d.bus.addr_strobe_oe = cpu_addr_strobe_oe_i;
      d.bus.rdwr_oe = cpu_rdwr_oe_i;
      d.bus.wait_oe = cpu_wait_oe_i;
      d.bus.al = cpu_addr_low_i;
    end
  end

  // reset touches only control state; ram has no clear path here
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      q.mode <= SSC_RUN;
      q.standby_reg <= STANDBY_RST;
      q.settle_sel <= SETTLE_SEL_RST;
      q.pcfg <= PCFG_RST;
      q.rdata <= 8'h00;
      q.gate <= '1;
      q.gate.i2c <= 1'b0;
      q.bus <= '0;
      q.osc_en <= 1'b1;
      q.sub_en <= 1'b0;
      q.cpu_run <= 1'b0;
      q.latch_hold <= 1'b0;
      q.irq_hold <= 1'b0;
      q.boot_vec <= 1'b1;
      q.settle_go <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign rdata_o = q.rdata;
  assign bus_o = q.bus;
  assign gate_o = q.gate;
  assign main_osc_en_o = q.osc_en;
  assign sub_osc_en_o = q.sub_en;
  assign cpu_run_o = q.cpu_run;
  assign latch_hold_o = q.latch_hold;
  assign irq_hold_o = q.irq_hold;
  assign boot_vec_o = q.boot_vec;

endmodule

// [dv/ssc_stop_ctrl_props.sv]
`timescale 1ns/1ps
module ssc_stop_ctrl_props
  import ssc_pkg::*;
#(
  parameter int SETTLE_BASE = SETTLE_BASE_DFLT
)(
  input wire logic       mclk_i,
  input wire logic       rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       we_i,
  input wire logic       re_i,
  input wire logic       spec_mov_i,
  input wire logic [7:0] rdata_o,
  input wire ssc_wake_s  wake_src_i,
  input wire ssc_bus_s   bus_o,
  input wire ssc_gate_s  gate_o,
  input wire logic       main_osc_en_o,
  input wire logic       cpu_run_o,
  input wire logic       latch_hold_o,
  input wire logic       irq_hold_o,
  input wire logic       boot_vec_o
);
  // bound holds while base plus osc_settle_select_reg is at most 5, so for a base of 1 only with select up to 4
  localparam int SETTLE_MAX = 40;
  logic stb_wr;
  logic wake_now;
  logic wake_any;
  assign stb_wr = we_i && addr_i == ADDR_STANDBY && wdata_i[STANDBY_STOP_BIT];
  assign wake_now = (|(wake_src_i.ext_req & ~wake_src_i.ext_mk))
                 || (|(wake_src_i.key_req & ~wake_src_i.key_mk)) || wake_src_i.nmi_edge;
  // watch timer counted as a wake whatever its gating, so holds stay safe
  assign wake_any = wake_now || wake_src_i.wt_req;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_restart;
    main_osc_en_o ##[1:SETTLE_MAX] cpu_run_o;
  endsequence
  chk_stop_entry: assert property (stb_wr && spec_mov_i && cpu_run_o && !wake_any
    |-> ##2 (!main_osc_en_o && !cpu_run_o)) else $error("stop not entered");
  chk_plain_ignored: assert property (stb_wr && !spec_mov_i && cpu_run_o
    |-> ##2 cpu_run_o) else $error("plain write entered stop");
  chk_pend_entry: assert property (stb_wr && spec_mov_i && cpu_run_o && wake_now
    |-> ##2 (main_osc_en_o && !cpu_run_o)) else $error("pending wake ignored");
  chk_wake_release: assert property (!main_osc_en_o && wake_now |-> ##[1:2] s_restart)
    else $error("release sequence wrong");
  chk_stop_holds: assert property (!main_osc_en_o && !wake_any |=> !main_osc_en_o)
    else $error("stop left without wake");
  chk_stop_state: assert property (!main_osc_en_o |-> !cpu_run_o && latch_hold_o && irq_hold_o
    && !gate_o.tmr16 && !gate_o.i2c && !gate_o.adc && gate_o.dac
    && bus_o == {5'h00, ADDR_LOW_STOP}) else $error("stop state wrong");
  chk_rdata_idle: assert property (!$past(re_i) |-> rdata_o == 8'h00)
    else $error("read data outside slot");
  chk_boot_vec: assert property ($past(rst_i) |=> !boot_vec_o && cpu_run_o)
    else $error("reset restart wrong");
endmodule
bind ssc_stop_ctrl ssc_stop_ctrl_props #(.SETTLE_BASE(SETTLE_BASE)) u_props (
  .mclk_i, .rst_i, .addr_i, .wdata_i, .we_i, .re_i, .spec_mov_i, .rdata_o, .wake_src_i,
  .bus_o, .gate_o, .main_osc_en_o, .cpu_run_o, .latch_hold_o, .irq_hold_o, .boot_vec_o);

// [dv/ssc_far_model.sv]
`timescale 1ns/1ps
module ssc_far_model
  import ssc_pkg::*;
(
  input  wire logic      mclk_i,
  input  wire logic      rst_i,
  input  wire logic      clr_i,
  input  wire ssc_wake_s raise_i,
  input  wire ssc_wake_s mask_i,
  output ssc_wake_s      wake_o,
  output logic     [7:0] addr_low_o,
  output logic           oe_o
);
  ssc_wake_s req_q;
  // flags stay set until serviced, like real sources
  always_ff @(posedge mclk_i) begin
    if (rst_i || clr_i) begin
      req_q <= '0;
    end else begin
      req_q <= req_q | raise_i;
    end
  end
  always_comb begin
    wake_o        = req_q;
    wake_o.ext_mk = mask_i.ext_mk;
    wake_o.wt_mk  = mask_i.wt_mk;
    wake_o.key_mk = mask_i.key_mk;
  end
  // cpu runs from the main clock and keeps its bus driven
  assign addr_low_o = 8'h3C;
  assign oe_o       = 1'b1;
endmodule

// [dv/testbench.sv]
`timescale 1ns/1ps
module testbench
  import ssc_pkg::*;
;
  logic       mclk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       we_i = 1'b0;
  logic       re_i = 1'b0;
  logic       spec_mov_i = 1'b0;
  logic       clr = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rdata_o, cpu_al;
  logic       cpu_oe, m_osc, s_osc, run, l_hold, i_hold, boot;
  ssc_wake_s  wake;
  ssc_wake_s  raise = '0;
  ssc_wake_s  mask = '{ext_mk: 7'h7F, key_mk: 8'h7F, default: '0};
  ssc_bus_s   bus;
  ssc_gate_s  gate;
  int         n_fail = 0;
  int         checks_done = 0;
  int         n;
  logic [7:0]  cfg [3] = '{8'h89, 8'h5E, 8'h30};
  logic [10:0] gexp [3] = '{11'h0CC, 11'h30E, 11'h008};
  ssc_wake_s   bad [3] = '{'{ext_req: 7'h40, default: '0}, '{wt_req: 1'b1, default: '0},
                           '{key_req: 8'h01, default: '0}};
  ssc_wake_s   good [3] = '{'{wt_req: 1'b1, default: '0}, '{key_req: 8'h80, default: '0},
                            '{nmi_edge: 1'b1, default: '0}};
  ssc_stop_ctrl #(.SETTLE_BASE(1)) u_ssc_stop_ctrl (
    .mclk_i, .rst_i, .addr_i, .wdata_i, .we_i, .re_i, .spec_mov_i, .rdata_o,
    .wake_src_i(wake), .cpu_addr_low_i(cpu_al), .cpu_ad_oe_i(cpu_oe), .cpu_ah_oe_i(cpu_oe),
    .cpu_addr_strobe_oe_i(cpu_oe), .cpu_rdwr_oe_i(cpu_oe), .cpu_wait_oe_i(cpu_oe), .bus_o(bus),
    .gate_o(gate), .main_osc_en_o(m_osc), .sub_osc_en_o(s_osc), .cpu_run_o(run),
    .latch_hold_o(l_hold), .irq_hold_o(i_hold), .boot_vec_o(boot));
  ssc_far_model u_ssc_far_model (.mclk_i, .rst_i, .clr_i(clr), .raise_i(raise),
    .mask_i(mask), .wake_o(wake), .addr_low_o(cpu_al), .oe_o(cpu_oe));
  initial begin
    forever #25 mclk_i = ~mclk_i;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge mclk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic s);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    spec_mov_i <= s;
    @(posedge mclk_i);
    we_i <= 1'b0;
    spec_mov_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge mclk_i);
    re_i <= 1'b0;
    #1;
    chk(16'(rdata_o), 16'(e));
  endtask
  // bounded wait; the caller checks the settle length, with an upper bound only for select 0
  task automatic wait_run();
    n = 0;
    while (run !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
  endtask
  task automatic clear_src();
    @(posedge mclk_i);
    raise <= '0;
    clr <= 1'b1;
    @(posedge mclk_i);
    clr <= 1'b0;
  endtask
  initial begin
    repeat (3000) @(posedge mclk_i);
    n_fail++;
    report_and_stop();
  end
  initial begin
    tick(5);
    chk(16'({boot, run, m_osc}), 16'h0005);
    @(posedge mclk_i);
    rst_i <= 1'b0;
    tick(2);
    chk(16'({boot, run, m_osc}), 16'h0003);
    chk(16'(gate), 16'h07FE);
    chk(16'(bus), 16'h1F3C);
    rd(ADDR_SETTLE_SEL, 8'(SETTLE_SEL_RST));
    rd(8'h55, 8'h00);
    wr(ADDR_SETTLE_SEL, 8'h00, 1'b0);
    wr(ADDR_STANDBY, 8'h02, 1'b0);
    tick(2);
    chk(16'(run), 16'h0001);
    rd(ADDR_STAT, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_PCFG, cfg[i], 1'b0);
      wr(ADDR_STANDBY, 8'hFF, 1'b1);
      // no bus access after entry, the cpu idles as its no-ops would
      tick(2);
      chk(16'({run, m_osc, s_osc, l_hold, i_hold}), 16'({2'b00, cfg[i][7], 2'b11}));
      chk(16'(gate), 16'(gexp[i]));
      chk(16'(bus), 16'h00C0);
      rd(ADDR_STAT, 8'h01);
      rd(ADDR_STANDBY, 8'h02);
      @(posedge mclk_i);
      raise <= bad[i];
      tick(4);
      chk(16'({run, m_osc}), 16'h0000);
      @(posedge mclk_i);
      raise <= good[i];
      wait_run();
      chk(16'(n >= 4 && n < 12), 16'h0001);
      chk(16'({run, m_osc, l_hold, bus}), 16'hDF3C);
      rd(ADDR_STANDBY, 8'h00);
      clear_src();
    end
    mask <= '{ext_mk: 7'h7E, key_mk: 8'hFF, default: '0};
    raise <= '{ext_req: 7'h01, default: '0};
    wr(ADDR_SETTLE_SEL, 8'h01, 1'b0);
    wr(ADDR_STANDBY, 8'h02, 1'b1);
    tick(2);
    chk(16'({run, m_osc}), 16'h0001);
    wait_run();
    chk(16'(n >= 4 && run), 16'h0001);
    clear_src();
    wr(ADDR_STANDBY, 8'h02, 1'b1);
    tick(2);
    @(posedge mclk_i);
    rst_i <= 1'b1;
    tick(2);
    chk(16'(boot), 16'h0001);
    @(posedge mclk_i);
    rst_i <= 1'b0;
    tick(2);
    chk(16'({boot, run, m_osc}), 16'h0003);
    rd(ADDR_STANDBY, 8'h00);
    report_and_stop();
  end
endmodule
